//--- bench/svs_partner.sv
`timescale 1ns/1ps
module svs_partner
(
   input wire sys_clk,
   input wire slow,
   input wire rf_req,
   input wire rf_we,
   input wire [7:0] rf_addr,
   input wire [15:0] rf_wdata,
   output reg rf_ack = 1'b0,
   output reg [63:0] rf_rdata = 64'h0,
   input wire mem_req,
   input wire mem_we,
   input wire [1:0] mem_size,
   input wire [47:0] mem_addr,
   input wire [63:0] mem_wdata,
   output reg mem_ack = 1'b0,
   output reg [63:0] mem_rdata = 64'h0,
   input wire ar_req,
   input wire [63:0] ar_a,
   input wire [63:0] ar_b,
   output reg ar_ack = 1'b0,
   output reg [63:0] ar_res = 64'h0,
   output wire [7:0] ar_flags
);
   reg [63:0] rf [0:255];
   reg [63:0] mem [0:255];
   wire [7:0] wi = mem_addr[13:6];
   wire [5:0] o = mem_addr[5:0];
   assign ar_flags = 8'h21;
   // Released data buses toggle so a late sample never sees the old answer.
   always @(posedge sys_clk)
   begin
      rf_ack <= rf_req && !rf_ack && !slow;
      mem_ack <= mem_req && !mem_ack && !slow;
      ar_ack <= ar_req && !ar_ack && !slow;
      rf_rdata <= ~rf_rdata;
      mem_rdata <= ~mem_rdata;
      ar_res <= ~ar_res;
      if (rf_req && !rf_ack && !slow)
      begin
         rf_rdata <= rf[rf_addr];
         if (rf_we)
            rf[rf_addr][63:48] <= rf_wdata;
      end
      if (mem_req && !mem_ack && !slow)
      begin
         mem_rdata <= mem[wi];
         if (mem_we && mem_size == 2'h0)
            mem[wi] <= mem_wdata;
         if (mem_we && mem_size == 2'h1 && o[5])
            mem[wi][31:0] <= mem_wdata[31:0];
         if (mem_we && mem_size == 2'h1 && !o[5])
            mem[wi][63:32] <= mem_wdata[31:0];
         if (mem_we && mem_size == 2'h2)
            mem[wi][63 - o] <= mem_wdata[0];
      end
      if (ar_req && !ar_ack && !slow)
         ar_res <= ar_a + ar_b;
   end
endmodule // svs_partner

//--- bench/svs_seq_asserts.sv
`timescale 1ns/1ps
`include "svs_map.vh"
module svs_seq_asserts #(
   parameter LW = 16
)
(
   input wire sys_clk,
   input wire rst_b,
   input wire [4:0] avs_address,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire avs_waitrequest,
   input wire rf_req,
   input wire rf_we,
   input wire [7:0] rf_addr,
   input wire [LW-1:0] rf_wdata,
   input wire rf_ack,
   input wire mem_req,
   input wire mem_we,
   input wire [1:0] mem_size,
   input wire mem_ack,
   input wire ar_req,
   input wire [7:0] ar_op,
   input wire [2:0] ar_sign,
   input wire ar_prec32,
   input wire ar_x,
   input wire ar_y,
   input wire [63:0] ar_a,
   input wire [63:0] ar_b,
   input wire busy
);
   reg [63:0] ins;
   reg [3:0] rn;
   reg [LW-1:0] wn;
   wire acc = avs_write && !avs_waitrequest;
   wire go = acc && avs_address[4:2] == 3'h0 && avs_writedata[0] && avs_byteenable[0] && !busy;
   wire [7:0] nd = rn == 4'h0 ? ins[7:0] : rn == 4'h1 ? ins[47:40] : rn == 4'h2 ? ins[39:32] :
      rn == 4'h3 ? ins[31:24] : rn == 4'h4 ? ins[23:16] : ins[15:8];
   // The shadow copy assumes whole-word instruction writes while idle.
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ins <= `SVS_INSTR_RST;
         rn <= 4'h0;
         wn <= {LW{1'b0}};
      end
      else
      begin
         if (acc && avs_address == `SVS_A_INSTR_HI && !busy)
            ins[63:32] <= avs_writedata;
         if (acc && avs_address == `SVS_A_INSTR_LO && !busy)
            ins[31:0] <= avs_writedata;
         if (go)
         begin
            rn <= 4'h0;
            wn <= {LW{1'b0}};
         end
         else
         begin
            if (rf_ack && !rf_we)
               rn <= rn + 4'h1;
            if (mem_ack && mem_we && mem_size != `SVS_SZ_BIT)
               wn <= wn + 1'b1;
         end
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_RF_ORDER: assert property (
      $rose(rf_req) && !rf_we && rn < 4'h6 |-> rf_addr == nd) else $error("fetch order wrong");
   AST_C_DESIG: assert property (
      rf_req && rf_we |-> rf_addr == ins[15:8]) else $error("count written to wrong register");
   AST_COUNT: assert property (
      rf_req && rf_we |-> rf_wdata == wn) else $error("count differs from stores");
   AST_NOOP: assert property (
      go && ins[7:0] == 8'h00 |=> (!busy && !rf_req && !mem_req) [*8]) else $error("noop ran");
   AST_PREC: assert property (
      mem_req && mem_size != `SVS_SZ_BIT |-> mem_size == (ins[55] ? `SVS_SZ_32 : `SVS_SZ_64))
      else $error("element size wrong");
   AST_SIGN: assert property (
      ar_req |-> ar_sign == ins[50:48] && ar_prec32 == ins[55] && ar_op == ins[63:56])
      else $error("sign control wrong");
   AST_NO_AR: assert property (
      ar_req |-> ins[63:56] != `SVS_OP_COMPRESS) else $error("compress used arithmetic");
   AST_MZ: assert property (
      ar_req && !ar_x && !ins[52] |-> ar_a == `SVS_MZ64) else $error("zero operand not used");
   AST_MZ_B: assert property (
      ar_req && !ar_y && !ins[51] |-> ar_b == `SVS_MZ64) else $error("zero operand B not used");
   AST_END: assert property (
      rf_ack && rf_we |-> ##[1:4] !busy) else $error("busy after completion");
endmodule // svs_seq_asserts

//--- bench/svs_seq_bench.sv
`timescale 1ns/1ps
`include "svs_map.vh"
module svs_seq_bench;
   reg sys_clk = 1'b0;
   reg rst_b = 1'b0;
   reg ce = 1'b1;
   reg slow = 1'b0;
   reg ck = 1'b0;
   reg avs_read = 1'b0;
   reg avs_write = 1'b0;
   reg [4:0] avs_address = 5'h00;
   reg [31:0] avs_writedata = 32'h0;
   reg [3:0] avs_byteenable = 4'hf;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, rf_req, rf_we, rf_ack, mem_req, mem_we, mem_ack;
   wire ar_req, ar_x, ar_y, ar_prec32, ar_ack, busy;
   wire [7:0] rf_addr, ar_op, ar_flags;
   wire [2:0] ar_sign;
   wire [15:0] rf_wdata;
   wire [1:0] mem_size;
   wire [47:0] mem_addr;
   wire [63:0] rf_rdata, mem_wdata, mem_rdata, ar_a, ar_b, ar_res;
   integer failures = 0;
   integer compares = 0;
   integer k;
   reg [63:0] q[$];
   reg [15:0] lf = 16'h2d4c;
   reg [15:0] ls = 16'h2d4c;
   reg [31:0] r;
   svs_seq dut (.*);
   svs_partner part (.*);
   function [15:0] nx(input [15:0] v);
      nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   initial
      forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      ls <= nx(ls);
      slow <= ls[0];
   end
   always @(posedge sys_clk)
      if (ck && avs_read && avs_waitrequest === 1'b0)
         chk("readdata", q.pop_front(), {32'h0, avs_readdata});
   task chk(input string nm, input [63:0] e, input [63:0] g);
   begin
      compares = compares + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   end
   endtask
   task close_out;
   begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   task bus(input w, input [4:0] ad, input [31:0] d, input c);
      integer n;
   begin
      n = 0;
      avs_address <= ad;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      ck <= c;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge sys_clk);
         n = n + 1;
      end
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      ck <= 1'b0;
      @(posedge sys_clk);
      if (n == 20)
      begin
         failures = failures + 1;
         close_out;
      end
   end
   endtask
   task rdx(input [4:0] ad, input [31:0] e);
   begin
      q.push_back({32'h0, e});
      bus(1'b0, ad, 32'h0, 1'b1);
   end
   endtask
   task run(input [7:0] f, input [7:0] g, input [7:0] zd, input [5:0] xb, input [5:0] yb,
      input [15:0] yl, input [15:0] zl);
      integer p, j, ia, ib, n;
      reg x, y, s, cp;
      reg [63:0] av, bv, ze, ev;
   begin
      cp = f == `SVS_OP_COMPRESS;
      for (p = 0; p < 24; p = p + 1)
      begin
         lf = nx(lf);
         part.mem[128 + p] = {lf, ~lf, lf ^ 16'h5a5a, lf};
      end
      part.rf[1] = {16'h0004, 48'h1000};
      part.rf[2] = {yl, 48'h1040};
      part.rf[3] = {16'hffff, 48'h2000};
      part.rf[4] = {16'hffff, 48'h2400};
      part.rf[5] = {16'h1234, 48'h2800};
      part.rf[6] = {zl, 48'h1080};
      part.mem[64] = {xb, 58'h0};
      part.mem[65] = {yb, 58'h0};
      part.mem[66] = 64'h0;
      bus(1'b1, `SVS_A_FLAGS, 32'hffffffff, 1'b0);
      bus(1'b1, `SVS_A_INSTR_HI, {f, g, 16'h0102}, 1'b0);
      bus(1'b1, `SVS_A_INSTR_LO, {24'h030405, zd}, 1'b0);
      bus(1'b1, `SVS_A_CTRL, 32'h1, 1'b0);
      n = 0;
      r = 32'h0;
      while (r[1] !== 1'b1 && n < 200)
      begin
         bus(1'b0, `SVS_A_STATUS, 32'h0, 1'b0);
         n = n + 1;
      end
      if (n == 200)
      begin
         failures = failures + 1;
         close_out;
      end
      n = zd == 8'h0 || zl == 16'h0;
      j = 0;
      ia = 0;
      ib = 0;
      ze = 64'h0;
      for (p = 0; p < (n ? 0 : zl); p = p + 1)
      begin
         x = p < 4 && xb[5 - p];
         y = p < yl && yb[5 - p];
         case (g[6:5])
            2'h0: s = f[3] ? x & y : x | y;
            2'h1: s = f[3] ? x | y : x & y;
            2'h2: s = x ^ y;
            default: s = x | !y;
         endcase
         if (cp)
            s = x;
         av = g[4] ? part.mem[128] : x ? part.mem[128 + ia] : 64'h0;
         bv = g[3] ? part.mem[144] : y ? part.mem[144 + ib] : 64'h0;
         if (cp)
         begin
            av = part.mem[128 + p / 2] >> (p % 2 ? 0 : 32);
            ev = part.mem[160 + j / 2] >> (j % 2 ? 0 : 32);
            if (s)
               chk("packed", av[31:0], ev[31:0]);
         end
         else if (s)
            chk("elem", av + bv, part.mem[160 + j]);
         ia = ia + x;
         ib = ib + y;
         j = j + s;
         ze[63 - p] = s;
      end
      rdx(`SVS_A_STATUS, n ? 32'h6 : 32'h2);
      if (!n)
         rdx(`SVS_A_COUNT, j);
      rdx(`SVS_A_FLAGS, (j > 0 && !cp) ? 32'h21 : 32'h0);
      chk("zvec", ze, part.mem[66]);
      chk("clen", {n ? 16'h1234 : j[15:0], 48'h2800}, part.rf[5]);
   end
   endtask
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rdx(`SVS_A_STATUS, 32'h0);
      bus(1'b1, 5'h1c, 32'hffffffff, 1'b0);
      rdx(5'h1c, 32'h0);
      for (k = 0; k < 8; k = k + 1)
         run(k[2] ? 8'ha8 : 8'ha0, {1'b0, k[1:0], 2'b00, k[2:0]}, 8'h06, 6'b101011,
            6'b110011, 16'h4, 16'h6);
      run(8'ha0, 8'h00, 8'h06, 6'b100100, 6'b111111, 16'h2, 16'h6);
      run(8'ha0, 8'h18, 8'h06, 6'b101011, 6'b110011, 16'h4, 16'h6);
      for (k = 0; k < 4; k = k + 1)
      begin
         lf = nx(lf);
         run(lf[8] ? 8'ha8 : 8'ha0, {1'b0, lf[1:0], 5'h0}, 8'h06, lf[7:2], lf[15:10],
            16'h6, 16'h6);
      end
      run(`SVS_OP_COMPRESS, 8'h80, 8'h06, 6'b110111, 6'h0, 16'h0, 16'h6);
      run(8'ha0, 8'h00, 8'h00, 6'h3f, 6'h3f, 16'h4, 16'h6);
      run(8'ha0, 8'h00, 8'h06, 6'h3f, 6'h3f, 16'h4, 16'h0);
      close_out;
   end
endmodule // svs_seq_bench
bind svs_seq svs_seq_asserts #(.LW(LW)) chk_i (.*);

//--- hw/svs_decode.v
`timescale 1ns/1ps
`include "svs_map.vh"
module svs_decode
(
   input wire [63:0] instr,
   output wire [7:0] f,
   output wire [7:0] g,
   output wire [7:0] dx,
   output wire [7:0] dy,
   output wire [7:0] da,
   output wire [7:0] db,
   output wire [7:0] dc,
   output wire [7:0] dz,
   output wire prec32,
   output wire [1:0] mode,
   output wire bca,
   output wire bcb,
   output wire [2:0] sign
);
   assign f = instr[`SVS_F_LO+7:`SVS_F_LO];
   assign g = instr[`SVS_G_LO+7:`SVS_G_LO];
   assign dx = instr[`SVS_X_LO+7:`SVS_X_LO];
   assign dy = instr[`SVS_Y_LO+7:`SVS_Y_LO];
   assign da = instr[`SVS_A_LO+7:`SVS_A_LO];
   assign db = instr[`SVS_B_LO+7:`SVS_B_LO];
   assign dc = instr[`SVS_C_LO+7:`SVS_C_LO];
   assign dz = instr[`SVS_Z_LO+7:`SVS_Z_LO];
   assign prec32 = g[`SVS_G_PREC];
   assign mode = {g[`SVS_G_MODE1], g[`SVS_G_MODE2]};
   assign bca = g[`SVS_G_BCA];
   assign bcb = g[`SVS_G_BCB];
   assign sign = g[`SVS_G_SIGN_HI:0];
endmodule // svs_decode

//--- hw/svs_map.vh
`ifndef SVS_MAP_VH
`define SVS_MAP_VH
// Avalon byte offsets.
`define SVS_A_CTRL 5'h00
`define SVS_A_STATUS 5'h04
`define SVS_A_INSTR_HI 5'h08
`define SVS_A_INSTR_LO 5'h0c
`define SVS_A_COUNT 5'h10
`define SVS_A_FLAGS 5'h14
// Control and status bit positions.
`define SVS_CTRL_START 0
`define SVS_ST_BUSY 0
`define SVS_ST_DONE 1
`define SVS_ST_NOOP 2
// Instruction designator low bit positions, bit 0 of the word is leftmost.
`define SVS_F_LO 56
`define SVS_G_LO 48
`define SVS_X_LO 40
`define SVS_Y_LO 32
`define SVS_A_LO 24
`define SVS_B_LO 16
`define SVS_C_LO 8
`define SVS_Z_LO 0
// Suboperation bit n sits at index 7-n of the field.
`define SVS_G_PREC 7
`define SVS_G_MODE1 6
`define SVS_G_MODE2 5
`define SVS_G_BCA 4
`define SVS_G_BCB 3
`define SVS_G_SIGN_HI 2
// Opcode bit that marks the multiply and divide class.
`define SVS_F_MUL 3
`define SVS_OP_COMPRESS 8'h0f
// Designated register layout: length in [63:48], base in [47:0].
`define SVS_LEN_LO 48
// Memory access sizes.
`define SVS_SZ_64 2'h0
`define SVS_SZ_32 2'h1
`define SVS_SZ_BIT 2'h2
// Reset values and machine zero images.
`define SVS_INSTR_RST 64'h0000000000000000
`define SVS_MZ64 64'h0000000000000000
`define SVS_MZ32 32'h00000000
`endif

//--- hw/svs_pick.v
`timescale 1ns/1ps
`include "svs_map.vh"
module svs_pick
(
   input wire [63:0] word,
   input wire [5:0] off,
   input wire [1:0] size,
   output reg [63:0] elem
);
   // Bit offset 0 is the leftmost bit of the word.
   always @*
   begin
      elem = 64'h0;
      case (size)
         `SVS_SZ_32: elem = {32'h0, off[5] ? word[31:0] : word[63:32]};
         `SVS_SZ_BIT: elem = {63'h0, word[6'h3f - off]};
         default: elem = word;
      endcase
   end
endmodule // svs_pick

//--- hw/svs_seq.v
`timescale 1ns/1ps
`include "svs_map.vh"
module svs_seq #(
   parameter AW = 48,
   parameter LW = 16,
   parameter FLAG_W = 8
)
(
   input wire sys_clk,
   input wire rst_b,
   input wire ce,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg rf_req,
   output reg rf_we,
   output reg [7:0] rf_addr,
   output reg [LW-1:0] rf_wdata,
   input wire rf_ack,
   input wire [63:0] rf_rdata,
   output reg mem_req,
   output reg mem_we,
   output reg [1:0] mem_size,
   output reg [AW-1:0] mem_addr,
   output reg [63:0] mem_wdata,
   input wire mem_ack,
   input wire [63:0] mem_rdata,
   output reg ar_req,
   output reg [7:0] ar_op,
   output reg [2:0] ar_sign,
   output reg ar_prec32,
   output reg ar_x,
   output reg ar_y,
   output reg [63:0] ar_a,
   output reg [63:0] ar_b,
   input wire ar_ack,
   input wire [63:0] ar_res,
   input wire [FLAG_W-1:0] ar_flags,
   output reg busy
);
   localparam S_IDLE = 12'h001;
   localparam S_RF = 12'h002;
   localparam S_BA = 12'h004;
   localparam S_BB = 12'h008;
   localparam S_XB = 12'h010;
   localparam S_YB = 12'h020;
   localparam S_DA = 12'h040;
   localparam S_DB = 12'h080;
   localparam S_OP = 12'h100;
   localparam S_WD = 12'h200;
   localparam S_WZ = 12'h400;
   localparam S_LEN = 12'h800;

   reg [11:0] state;
   reg [63:0] instr;
   reg [2:0] rf_idx;
   reg [AW-1:0] xb, yb, zb, aptr, bptr, cptr;
   reg [LW-1:0] xlen, ylen, zlen, pos, cnt;
   reg xbit, ybit, done, noop;
   reg [63:0] aval, bval, res;
   reg [FLAG_W-1:0] flags, rflags;
   wire [7:0] f, g, dx, dy, da, db, dc, dz;
   wire prec32, bca, bcb;
   wire [1:0] mode;
   wire [2:0] sign;
   wire [63:0] picked;

   svs_decode u_dec
   (
      .instr(instr),
      .f(f),
      .g(g),
      .dx(dx),
      .dy(dy),
      .da(da),
      .db(db),
      .dc(dc),
      .dz(dz),
      .prec32(prec32),
      .mode(mode),
      .bca(bca),
      .bcb(bcb),
      .sign(sign)
   );

   svs_pick u_pick
   (
      .word(mem_rdata),
      .off(mem_addr[5:0]),
      .size(mem_size),
      .elem(picked)
   );

   function [31:0] merge_be;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] be;
      integer i;
      begin
         merge_be = old_v;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge_be[i*8 +: 8] = new_v[i*8 +: 8];
      end
   endfunction

   function [AW-1:0] ext;
      input [LW-1:0] v;
      begin
         ext = {{(AW-LW){1'b0}}, v};
      end
   endfunction

   // Table of order combinations; mul picks the multiply/divide sense.
   function gen_bit;
      input [1:0] m;
      input mul;
      input x;
      input y;
      begin
         case (m)
            2'b00: gen_bit = mul ? (x & y) : (x | y);
            2'b01: gen_bit = mul ? (x | y) : (x & y);
            2'b10: gen_bit = x ^ y;
            default: gen_bit = x | ~y;
         endcase
      end
   endfunction

   wire cmp = (f == `SVS_OP_COMPRESS);
   wire gen = cmp ? xbit : gen_bit(mode, f[`SVS_F_MUL], xbit, ybit);
   wire [AW-1:0] esz = prec32 ? ext(16'd32) : ext(16'd64);
   wire [1:0] esize = prec32 ? `SVS_SZ_32 : `SVS_SZ_64;
   wire [63:0] mz = prec32 ? {32'h0, `SVS_MZ32} : `SVS_MZ64;
   wire acc = !avs_waitrequest && ce;
   wire wacc = acc && avs_write;
   wire start = wacc && avs_address == `SVS_A_CTRL && avs_byteenable[0]
                && avs_writedata[`SVS_CTRL_START] && !busy;
   wire stored = state == S_WD && mem_req && mem_ack && !cmp;
   wire [FLAG_W-1:0] flag_clr = (wacc && avs_address == `SVS_A_FLAGS)
                                ? avs_writedata[FLAG_W-1:0] : {FLAG_W{1'b0}};
   wire [FLAG_W-1:0] flag_set = stored ? rflags : {FLAG_W{1'b0}};
   wire [LW-1:0] pos_nx = pos + 16'd1;

   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avs_readdata <= 32'h0;
         avs_waitrequest <= 1'b1;
         rf_req <= 1'b0;
         rf_we <= 1'b0;
         rf_addr <= 8'h0;
         rf_wdata <= {LW{1'b0}};
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_size <= `SVS_SZ_64;
         mem_addr <= {AW{1'b0}};
         mem_wdata <= 64'h0;
         ar_req <= 1'b0;
         ar_op <= 8'h0;
         ar_sign <= 3'h0;
         ar_prec32 <= 1'b0;
         ar_x <= 1'b0;
         ar_y <= 1'b0;
         ar_a <= 64'h0;
         ar_b <= 64'h0;
         busy <= 1'b0;
         state <= S_IDLE;
         instr <= `SVS_INSTR_RST;
         rf_idx <= 3'h0;
         xb <= {AW{1'b0}};
         yb <= {AW{1'b0}};
         zb <= {AW{1'b0}};
         aptr <= {AW{1'b0}};
         bptr <= {AW{1'b0}};
         cptr <= {AW{1'b0}};
         xlen <= {LW{1'b0}};
         ylen <= {LW{1'b0}};
         zlen <= {LW{1'b0}};
         pos <= {LW{1'b0}};
         cnt <= {LW{1'b0}};
         xbit <= 1'b0;
         ybit <= 1'b0;
         done <= 1'b0;
         noop <= 1'b0;
         aval <= 64'h0;
         bval <= 64'h0;
         res <= 64'h0;
         flags <= {FLAG_W{1'b0}};
         rflags <= {FLAG_W{1'b0}};
      end
      else if (ce)
      begin
         // One wait cycle per access keeps readdata a registered output.
         if ((avs_read || avs_write) && avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            case (avs_address)
               `SVS_A_STATUS: avs_readdata <= {29'h0, noop, done, busy};
               `SVS_A_INSTR_HI: avs_readdata <= instr[63:32];
               `SVS_A_INSTR_LO: avs_readdata <= instr[31:0];
               `SVS_A_COUNT: avs_readdata <= {{(32-LW){1'b0}}, cnt};
               `SVS_A_FLAGS: avs_readdata <= {{(32-FLAG_W){1'b0}}, flags};
               default: avs_readdata <= 32'h0;
            endcase
         end
         else
            avs_waitrequest <= 1'b1;
         // The instruction is frozen while a sequence runs.
         if (wacc && !busy && avs_address == `SVS_A_INSTR_HI)
            instr[63:32] <= merge_be(instr[63:32], avs_writedata, avs_byteenable);
         if (wacc && !busy && avs_address == `SVS_A_INSTR_LO)
            instr[31:0] <= merge_be(instr[31:0], avs_writedata, avs_byteenable);
         // A flag raised in the clearing cycle survives.
         flags <= (flags & ~flag_clr) | flag_set;
         case (state)
            S_IDLE:
            begin
               if (start)
               begin
                  done <= 1'b0;
                  cnt <= {LW{1'b0}};
                  pos <= {LW{1'b0}};
                  rf_idx <= 3'h0;
                  if (dz == 8'h0)
                  begin
                     noop <= 1'b1;
                     done <= 1'b1;
                  end
                  else
                  begin
                     noop <= 1'b0;
                     busy <= 1'b1;
                     state <= S_RF;
                  end
               end
            end
            S_RF:
            begin
               if (!rf_req)
               begin
                  rf_req <= 1'b1;
                  rf_we <= 1'b0;
                  case (rf_idx)
                     3'h0: rf_addr <= dz;
                     3'h1: rf_addr <= dx;
                     3'h2: rf_addr <= dy;
                     3'h3: rf_addr <= da;
                     3'h4: rf_addr <= db;
                     default: rf_addr <= dc;
                  endcase
               end
               else if (rf_ack)
               begin
                  rf_req <= 1'b0;
                  rf_idx <= rf_idx + 3'h1;
                  case (rf_idx)
                     3'h0:
                     begin
                        zb <= rf_rdata[AW-1:0];
                        zlen <= rf_rdata[`SVS_LEN_LO +: LW];
                        if (rf_rdata[`SVS_LEN_LO +: LW] == {LW{1'b0}})
                        begin
                           noop <= 1'b1;
                           done <= 1'b1;
                           busy <= 1'b0;
                           state <= S_IDLE;
                        end
                     end
                     3'h1:
                     begin
                        xb <= rf_rdata[AW-1:0];
                        xlen <= rf_rdata[`SVS_LEN_LO +: LW];
                     end
                     3'h2:
                     begin
                        yb <= rf_rdata[AW-1:0];
                        ylen <= rf_rdata[`SVS_LEN_LO +: LW];
                     end
                     3'h3: aptr <= rf_rdata[AW-1:0];
                     3'h4: bptr <= rf_rdata[AW-1:0];
                     default:
                     begin
                        cptr <= rf_rdata[AW-1:0];
                        state <= bca ? S_BA : (bcb && !cmp) ? S_BB : S_XB;
                     end
                  endcase
               end
            end
            S_BA, S_BB:
            begin
               // A broadcast value is fetched once and never advances.
               if (!mem_req)
               begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_size <= esize;
                  mem_addr <= state == S_BA ? aptr : bptr;
               end
               else if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  if (state == S_BA)
                  begin
                     aval <= picked;
                     state <= (bcb && !cmp) ? S_BB : S_XB;
                  end
                  else
                  begin
                     bval <= picked;
                     state <= S_XB;
                  end
               end
            end
            S_XB, S_YB:
            begin
               if ((state == S_XB ? pos >= xlen : (pos >= ylen || cmp)))
               begin
                  if (state == S_XB)
                     xbit <= 1'b0;
                  else
                     ybit <= 1'b0;
                  state <= state == S_XB ? S_YB : S_DA;
               end
               else if (!mem_req)
               begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_size <= `SVS_SZ_BIT;
                  mem_addr <= (state == S_XB ? xb : yb) + ext(pos);
               end
               else if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  if (state == S_XB)
                     xbit <= picked[0];
                  else
                     ybit <= picked[0];
                  state <= state == S_XB ? S_YB : S_DA;
               end
            end
            S_DA, S_DB:
            begin
               // Compress walks a dense source, so unless A is broadcast it reads A every position.
               if (state == S_DA ? (bca || !(xbit || cmp)) : (bcb || cmp || !ybit))
               begin
                  if (state == S_DA && !bca)
                     aval <= mz;
                  if (state == S_DB && !bcb)
                     bval <= mz;
                  state <= state == S_DA ? S_DB : S_OP;
               end
               else if (!mem_req)
               begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_size <= esize;
                  mem_addr <= state == S_DA ? aptr : bptr;
               end
               else if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  if (state == S_DA)
                  begin
                     aval <= picked;
                     aptr <= aptr + esz;
                     state <= S_DB;
                  end
                  else
                  begin
                     bval <= picked;
                     bptr <= bptr + esz;
                     state <= S_OP;
                  end
               end
            end
            S_OP:
            begin
               if (!gen)
                  state <= S_WZ;
               else if (cmp)
               begin
                  res <= aval;
                  state <= S_WD;
               end
               else if (!ar_req)
               begin
                  ar_req <= 1'b1;
                  ar_op <= f;
                  ar_sign <= sign;
                  ar_prec32 <= prec32;
                  ar_x <= xbit;
                  ar_y <= ybit;
                  ar_a <= aval;
                  ar_b <= bval;
               end
               else if (ar_ack)
               begin
                  ar_req <= 1'b0;
                  res <= ar_res;
                  rflags <= ar_flags;
                  state <= S_WD;
               end
            end
            S_WD:
            begin
               if (!mem_req)
               begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_size <= esize;
                  mem_addr <= cptr;
                  mem_wdata <= res;
               end
               else if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  cptr <= cptr + esz;
                  cnt <= cnt + 16'd1;
                  state <= S_WZ;
               end
            end
            S_WZ:
            begin
               if (!mem_req)
               begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_size <= `SVS_SZ_BIT;
                  mem_addr <= zb + ext(pos);
                  mem_wdata <= {63'h0, gen};
               end
               else if (mem_ack)
               begin
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  pos <= pos_nx;
                  state <= (pos_nx == zlen) ? S_LEN : S_XB;
               end
            end
            S_LEN:
            begin
               if (!rf_req)
               begin
                  rf_req <= 1'b1;
                  rf_we <= 1'b1;
                  rf_addr <= dc;
                  rf_wdata <= cnt;
               end
               else if (rf_ack)
               begin
                  rf_req <= 1'b0;
                  rf_we <= 1'b0;
                  done <= 1'b1;
                  busy <= 1'b0;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // svs_seq
